// ---- hdl/sp_regs.svh ----
/*
 Register offsets, field positions, reset values and counts of the serial port.
 Assumes a 16-bit register port with word offsets as printed.
*/
`ifndef SP_REGS_SVH
`define SP_REGS_SVH

`define SP_CTRL_OFS 16'hC070
`define SP_BAUD_OFS 16'hC072
`define SP_GAP_OFS 16'hC074
`define SP_TXDATA_OFS 16'hC076
`define SP_RXDATA_OFS 16'hC078
`define SP_STATUS_OFS 16'hC07A
`define SP_IRQ_STAT_OFS 16'hC07C
`define SP_IRQ_MASK_OFS 16'hC07E
`define SP_BLK_ADDR_OFS 16'hC080

`define SP_CTRL_BLKTX 0
`define SP_CTRL_BLKRX 1
`define SP_CTRL_FLOW 2

`define SP_IRQ_RXBYTE 0
`define SP_IRQ_TXDONE 1
`define SP_IRQ_OVERRUN 2
`define SP_IRQ_FRAMING 3

`define SP_CTRL_RST 3'h0
`define SP_BAUD_RST 16'h0017
`define SP_GAP_RST 16'h000B
`define SP_GAP_FRAME_BITS 16'h0009
`define SP_FIFO_DEPTH 4'h8
`define SP_RTS_DROP_BIT 3'h2
`define SP_LAST_BIT 3'h7

`endif

// ---- hdl/sp_pkg.sv ----
/*
 Types shared by the serial port and its receive buffer.
 Assumes sp_regs.svh supplies the numeric constants.
*/
`default_nettype none
package sp_pkg;
    typedef logic [15:0] reg_addr_t;
    typedef logic [15:0] reg_data_t;
    typedef logic [2:0] fifo_ptr_t;
    typedef enum logic [4:0] {
        T_IDLE = 5'h01,
        T_WAIT = 5'h02,
        T_START = 5'h04,
        T_DATA = 5'h08,
        T_STOP = 5'h10
    } tx_state_t;
    typedef enum logic [3:0] {
        R_IDLE = 4'h1,
        R_START = 4'h2,
        R_DATA = 4'h4,
        R_STOP = 4'h8
    } rx_state_t;
endpackage
`default_nettype wire

// ---- hdl/rx_fifo_if.sv ----
/*
 Connection between the port logic and its receive byte store.
 Assumes one clock, driven by the port logic.
*/
`timescale 1ns/1ps
`default_nettype none
interface rx_fifo_if (input wire logic clk);
    logic ce;
    logic wr_en;
    sp_pkg::fifo_ptr_t wr_addr;
    logic [7:0] wr_data;
    sp_pkg::fifo_ptr_t rd_addr;
    logic [7:0] rd_data;
    modport port (output ce, output wr_en, output wr_addr, output wr_data,
        output rd_addr, input rd_data, input clk);
    modport mem (input ce, input wr_en, input wr_addr, input wr_data,
        input rd_addr, output rd_data, input clk);
endinterface
`default_nettype wire

// ---- hdl/rx_fifo_mem.sv ----
/*
 Eight-byte store for received bytes, read data from a register.
 Assumes the port logic keeps the pointers and the fill count.
*/
`timescale 1ns/1ps
`default_nettype none
module rx_fifo_mem (
    rx_fifo_if.mem bus
);
    import sp_pkg::*;
    logic [7:0] store_q [8];

    always_ff @(posedge bus.clk) begin
        if (bus.ce) begin
            if (bus.wr_en) begin
                store_q[bus.wr_addr] <= bus.wr_data;
            end
            bus.rd_data <= store_q[bus.rd_addr];
        end
    end
endmodule // rx_fifo_mem
`default_nettype wire

// ---- hdl/high_speed_serial_port.sv ----
/*
 Asynchronous serial port: byte and block transmit and receive, optional
 request/clear-to-send handshake, receive FIFO, interrupt status.
 Assumes a 16-bit register port on sys_clk and line pins from outside.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sp_regs.svh"
module high_speed_serial_port (
    // Clock, reset, enable
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic ce,
    // Register port
    input wire sp_pkg::reg_addr_t reg_addr,
    input wire sp_pkg::reg_data_t reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output sp_pkg::reg_data_t reg_rdata,
    // Serial line
    input wire logic serial_rx_line,
    output logic serial_tx_line,
    input wire logic clear_to_send_in,
    output logic request_to_send_out,
    // Status
    output logic rx_byte_available,
    output logic irq,
    // Memory write path for block receive
    output logic mem_wr_en,
    output sp_pkg::reg_addr_t mem_wr_addr,
    output logic [7:0] mem_wr_data
);
    import sp_pkg::*;

    logic rx_m_q, rx_s_q, cts_m_q, cts_s_q;
    logic [2:0] ctrl_q;
    reg_data_t baud_q, gap_q, blk_addr_q;
    logic [3:0] irq_mask_q, irq_stat_q, irq_stat_d, events;
    tx_state_t tx_st_q, tx_st_d;
    reg_data_t tx_cnt_q, tx_cnt_d, stop_left_q, stop_left_d;
    logic [2:0] tx_bit_q, tx_bit_d;
    logic [7:0] tx_byte_q;
    logic tx_line_d, rts_d, tx_done;
    rx_state_t rx_st_q, rx_st_d;
    reg_data_t rx_cnt_q, rx_cnt_d;
    logic [2:0] rx_bit_q, rx_bit_d;
    logic [7:0] rx_sh_q, rx_sh_d;
    logic rx_done, rx_ferr;
    fifo_ptr_t wr_ptr_q, rd_ptr_q;
    logic [3:0] fill_q, fill_d;

    // Register decode
    wire wr_ctrl = reg_wr && (reg_addr == `SP_CTRL_OFS);
    wire wr_baud = reg_wr && (reg_addr == `SP_BAUD_OFS);
    wire wr_gap = reg_wr && (reg_addr == `SP_GAP_OFS);
    wire wr_txdata = reg_wr && (reg_addr == `SP_TXDATA_OFS);
    wire wr_mask = reg_wr && (reg_addr == `SP_IRQ_MASK_OFS);
    wire wr_blk = reg_wr && (reg_addr == `SP_BLK_ADDR_OFS);
    wire rd_rxdata = reg_rd && (reg_addr == `SP_RXDATA_OFS);
    wire rd_irq = reg_rd && (reg_addr == `SP_IRQ_STAT_OFS);
    wire blk_tx = ctrl_q[`SP_CTRL_BLKTX];
    wire blk_rx = ctrl_q[`SP_CTRL_BLKRX];
    wire flow_en = ctrl_q[`SP_CTRL_FLOW];
    wire tx_busy = (tx_st_q != T_IDLE);
    wire tx_load = wr_txdata && !tx_busy;

    rx_fifo_if fifo_bus (.clk(sys_clk));
    rx_fifo_mem u_store (.bus(fifo_bus.mem));

    // Pin synchronisers
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rx_m_q <= 1'b1;
            rx_s_q <= 1'b1;
            cts_m_q <= 1'b0;
            cts_s_q <= 1'b0;
        end else if (ce) begin
            rx_m_q <= serial_rx_line;
            rx_s_q <= rx_m_q;
            cts_m_q <= clear_to_send_in;
            cts_s_q <= cts_m_q;
        end
    end

    // Software registers
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_q <= `SP_CTRL_RST;
            baud_q <= `SP_BAUD_RST;
            gap_q <= `SP_GAP_RST;
            irq_mask_q <= 4'h0;
            tx_byte_q <= 8'h00;
        end else if (ce) begin
            if (wr_ctrl) ctrl_q <= reg_wdata[2:0];
            if (wr_baud) baud_q <= reg_wdata;
            if (wr_gap) gap_q <= reg_wdata;
            if (wr_mask) irq_mask_q <= reg_wdata[3:0];
            if (tx_load) tx_byte_q <= reg_wdata[7:0];
        end
    end

    // Transmitter
    wire tx_tick = (tx_cnt_q == 16'h0000);
    wire [15:0] gap_bits = gap_q - `SP_GAP_FRAME_BITS;
    wire gap_long = (gap_q > `SP_GAP_FRAME_BITS);
    wire [15:0] stop_bits = (blk_tx && gap_long) ? gap_bits : 16'h0001;

    always_comb begin
        tx_st_d = tx_st_q;
        tx_cnt_d = tx_tick ? baud_q : tx_cnt_q - 16'h0001;
        tx_bit_d = tx_bit_q;
        stop_left_d = stop_left_q;
        tx_done = 1'b0;
        case (tx_st_q)
            T_IDLE: begin
                if (tx_load) tx_st_d = T_WAIT;
            end
            T_WAIT: begin
                tx_cnt_d = baud_q;
                if (!flow_en || cts_s_q) tx_st_d = T_START;
            end
            T_START: begin
                if (tx_tick) begin
                    tx_st_d = T_DATA;
                    tx_bit_d = 3'h0;
                end
            end
            T_DATA: begin
                if (tx_tick) begin
                    if (tx_bit_q == `SP_LAST_BIT) begin
                        tx_st_d = T_STOP;
                        stop_left_d = stop_bits - 16'h0001;
                    end else begin
                        tx_bit_d = tx_bit_q + 3'h1;
                    end
                end
            end
            T_STOP: begin
                if (tx_tick) begin
                    if (stop_left_q == 16'h0000) begin
                        tx_st_d = T_IDLE;
                        tx_done = 1'b1;
                    end else begin
                        stop_left_d = stop_left_q - 16'h0001;
                    end
                end
            end
            default: tx_st_d = T_IDLE;
        endcase
    end

    // Line level follows the next state so it lines up with it
    assign tx_line_d = (tx_st_d == T_START) ? 1'b0 :
        (tx_st_d == T_DATA) ? tx_byte_q[tx_bit_d] : 1'b1;
    wire rts_drop = (tx_st_d == T_DATA) && (tx_bit_d == `SP_RTS_DROP_BIT);
    assign rts_d = tx_load ? flow_en : (rts_drop ? 1'b0 : request_to_send_out);

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            tx_st_q <= T_IDLE;
            tx_cnt_q <= 16'h0000;
            tx_bit_q <= 3'h0;
            stop_left_q <= 16'h0000;
            serial_tx_line <= 1'b1;
            request_to_send_out <= 1'b0;
        end else if (ce) begin
            tx_st_q <= tx_st_d;
            tx_cnt_q <= tx_cnt_d;
            tx_bit_q <= tx_bit_d;
            stop_left_q <= stop_left_d;
            serial_tx_line <= tx_line_d;
            request_to_send_out <= rts_d;
        end
    end

    // Receiver, samples each bit at its middle
    wire rx_tick = (rx_cnt_q == 16'h0000);

    always_comb begin
        rx_st_d = rx_st_q;
        rx_cnt_d = rx_tick ? baud_q : rx_cnt_q - 16'h0001;
        rx_bit_d = rx_bit_q;
        rx_sh_d = rx_sh_q;
        rx_done = 1'b0;
        rx_ferr = 1'b0;
        case (rx_st_q)
            R_IDLE: begin
                if (!rx_s_q) begin
                    rx_st_d = R_START;
                    rx_cnt_d = {1'b0, baud_q[15:1]};
                end
            end
            R_START: begin
                if (rx_tick) begin
                    rx_st_d = rx_s_q ? R_IDLE : R_DATA;
                    rx_bit_d = 3'h0;
                end
            end
            R_DATA: begin
                if (rx_tick) begin
                    rx_sh_d = {rx_s_q, rx_sh_q[7:1]};
                    if (rx_bit_q == `SP_LAST_BIT) rx_st_d = R_STOP;
                    else rx_bit_d = rx_bit_q + 3'h1;
                end
            end
            R_STOP: begin
                if (rx_tick) begin
                    rx_st_d = R_IDLE;
                    rx_done = rx_s_q;
                    rx_ferr = !rx_s_q;
                end
            end
            default: rx_st_d = R_IDLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rx_st_q <= R_IDLE;
            rx_cnt_q <= 16'h0000;
            rx_bit_q <= 3'h0;
            rx_sh_q <= 8'h00;
        end else if (ce) begin
            rx_st_q <= rx_st_d;
            rx_cnt_q <= rx_cnt_d;
            rx_bit_q <= rx_bit_d;
            rx_sh_q <= rx_sh_d;
        end
    end

    // Receive FIFO and block-mode memory path
    wire fifo_full = (fill_q == `SP_FIFO_DEPTH);
    wire fifo_push = rx_done && !blk_rx && !fifo_full;
    wire overrun = rx_done && !blk_rx && fifo_full;
    wire fifo_pop = rd_rxdata && (fill_q != 4'h0);
    wire blk_write = rx_done && blk_rx;
    assign fill_d = fill_q + {3'h0, fifo_push} - {3'h0, fifo_pop};
    assign fifo_bus.ce = ce;
    assign fifo_bus.wr_en = fifo_push && ce;
    assign fifo_bus.wr_addr = wr_ptr_q;
    assign fifo_bus.wr_data = rx_sh_q;
    assign fifo_bus.rd_addr = fifo_pop ? rd_ptr_q + 3'h1 : rd_ptr_q;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            wr_ptr_q <= 3'h0;
            rd_ptr_q <= 3'h0;
            fill_q <= 4'h0;
            rx_byte_available <= 1'b0;
            mem_wr_en <= 1'b0;
            mem_wr_addr <= 16'h0000;
            mem_wr_data <= 8'h00;
            blk_addr_q <= 16'h0000;
        end else if (ce) begin
            if (fifo_push) wr_ptr_q <= wr_ptr_q + 3'h1;
            if (fifo_pop) rd_ptr_q <= rd_ptr_q + 3'h1;
            fill_q <= fill_d;
            rx_byte_available <= (fill_q != 4'h0);
            mem_wr_en <= blk_write;
            if (blk_write) mem_wr_addr <= blk_addr_q;
            if (blk_write) mem_wr_data <= rx_sh_q;
            if (wr_blk) blk_addr_q <= reg_wdata;
            else if (blk_write) blk_addr_q <= blk_addr_q + 16'h0001;
        end
    end

    // Interrupt status, set wins over the clear on read
    assign events = {rx_ferr, overrun, tx_done, rx_done};
    assign irq_stat_d = (rd_irq ? 4'h0 : irq_stat_q) | events;
    wire [15:0] status_word = {8'h00, fill_q, 2'h0, tx_busy, rx_byte_available};
    wire [15:0] rd_mux =
        (reg_addr == `SP_CTRL_OFS) ? {13'h0000, ctrl_q} :
        (reg_addr == `SP_BAUD_OFS) ? baud_q :
        (reg_addr == `SP_GAP_OFS) ? gap_q :
        (reg_addr == `SP_RXDATA_OFS) ? {8'h00, fifo_bus.rd_data} :
        (reg_addr == `SP_STATUS_OFS) ? status_word :
        (reg_addr == `SP_IRQ_STAT_OFS) ? {12'h000, irq_stat_q} :
        (reg_addr == `SP_IRQ_MASK_OFS) ? {12'h000, irq_mask_q} :
        (reg_addr == `SP_BLK_ADDR_OFS) ? blk_addr_q : 16'h0000;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            irq_stat_q <= 4'h0;
            irq <= 1'b0;
            reg_rdata <= 16'h0000;
        end else if (ce) begin
            irq_stat_q <= irq_stat_d;
            irq <= |(irq_stat_q & irq_mask_q);
            reg_rdata <= reg_rd ? rd_mux : 16'h0000;
        end
    end

    // Checks
    logic [31:0] stop_clks_q;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) stop_clks_q <= 32'h0000_0000;
        else if (ce) stop_clks_q <= (tx_st_q == T_STOP) ? stop_clks_q + 32'h1 : 32'h0;
    end
    wire [31:0] bt_clks = {16'h0000, baud_q} + 32'h1;
    wire [31:0] stop_want = 32'(stop_bits * bt_clks);

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    idle_line_high_a: assert property (tx_st_q == T_IDLE |-> serial_tx_line)
        else $error("line not high while idle");
    start_bit_low_a: assert property (tx_st_q == T_START |-> !serial_tx_line)
        else $error("start bit not low");
    lsb_first_a: assert property ($rose(tx_st_q == T_DATA) |-> serial_tx_line == tx_byte_q[0])
        else $error("first data bit is not bit 0");
    block_gap_a: assert property (ce && tx_done && blk_tx && gap_long |->
        stop_clks_q + 32'h1 == stop_want)
        else $error("block stop length wrong");
    byte_stop_a: assert property (ce && tx_done && !blk_tx |-> stop_clks_q == {16'h0000, baud_q})
        else $error("byte stop not one bit time");
    gap_reset_a: assert property (!$past(rstn) |-> gap_q == `SP_GAP_RST)
        else $error("gap reset value wrong");
    cts_hold_a: assert property (ce && tx_st_q == T_WAIT && flow_en && !cts_s_q |=>
        tx_st_q == T_WAIT)
        else $error("start not held by clear-to-send");
    rts_drop_a: assert property ($fell(request_to_send_out) && !$past(tx_load) |->
        tx_st_q == T_DATA && tx_bit_q == `SP_RTS_DROP_BIT)
        else $error("request-to-send dropped outside third bit");
    rx_flag_a: assert property (ce && fill_q != 4'h0 ##1 ce |-> rx_byte_available)
        else $error("receive flag missing");
    block_path_a: assert property (ce && blk_write |-> !fifo_bus.wr_en ##1 mem_wr_en)
        else $error("block byte not sent to memory");
    rx_sync_a: assert property (rx_st_q == R_IDLE && rx_s_q && ce |=> rx_st_q == R_IDLE)
        else $error("receiver left idle without synchronised start");

    tx_byte_c: cover property (tx_done && !blk_tx);
    tx_block_c: cover property (tx_done && blk_tx && gap_long);
    cts_wait_c: cover property (tx_st_q == T_WAIT && !cts_s_q ##1 tx_st_q == T_START);
    rx_fifo_c: cover property (fifo_push ##[1:300] fifo_pop);
endmodule // high_speed_serial_port
`default_nettype wire

// ---- bench/line_partner.sv ----
/*
 Remote serial partner: sends bytes on the receive line, frames bytes seen
 on the transmit line, drives clear-to-send. Assumes sys_clk paces its receiver; sending uses bt_ns delays.
*/
`timescale 1ns/1ps
`default_nettype none
module line_partner #(
    parameter int BT = 24
) (
    // Clock
    input wire logic sys_clk,
    // Line
    input wire logic serial_tx_line,
    input wire logic request_to_send_out,
    output var logic serial_rx_line,
    output var logic clear_to_send_in
);
    logic cts_hold;
    logic [7:0] got_byte;
    initial begin
        serial_rx_line = 1'b1;
        clear_to_send_in = 1'b1;
        cts_hold = 1'b0;
        got_byte = 8'h00;
    end
    // Once raised, stays up until request drops
    always @(posedge sys_clk) begin
        clear_to_send_in <= !cts_hold || (clear_to_send_in && request_to_send_out);
    end
    always begin
        @(negedge serial_tx_line);
        repeat (BT / 2) @(posedge sys_clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BT) @(posedge sys_clk);
            got_byte[i] = serial_tx_line;
        end
    end
    // Starts on a falling clock edge so no line change meets a rising one
    task automatic send_byte(input logic [7:0] data, input realtime bt_ns);
        @(negedge sys_clk);
        serial_rx_line = 1'b0;
        #(bt_ns);
        for (int i = 0; i < 8; i++) begin
            serial_rx_line = data[i];
            #(bt_ns);
        end
        serial_rx_line = 1'b1;
        #(bt_ns * 2);
    endtask
endmodule // line_partner
`default_nettype wire

// ---- bench/high_speed_serial_port_tb.sv ----
/*
 Self-checking bench of the serial port: register tasks, line partner.
 Assumes the register map of sp_regs.svh and a 125 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sp_regs.svh"
module high_speed_serial_port_tb;
    import sp_pkg::*;
    localparam int BT = `SP_BAUD_RST + 1;
    localparam realtime BTNS = BT * 8.0;
    logic sys_clk, rstn, ce, reg_wr, reg_rd, rx_byte_available, irq, mem_wr_en;
    logic serial_rx_line, serial_tx_line, clear_to_send_in, request_to_send_out;
    reg_addr_t reg_addr, mem_wr_addr;
    reg_data_t reg_wdata, reg_rdata;
    logic [7:0] mem_wr_data;
    logic [23:0] mem_log [$];
    logic [7:0] rx_data [3] = '{8'h5A, 8'hC3, 8'h3C};
    real rx_scale [3] = '{1.0, 1.05, 0.95};
    int bad_count = 0;
    int samples_checked = 0;
    int n;

    high_speed_serial_port i_dut (.sys_clk(sys_clk), .rstn(rstn), .ce(ce),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .serial_rx_line(serial_rx_line),
        .serial_tx_line(serial_tx_line), .clear_to_send_in(clear_to_send_in),
        .request_to_send_out(request_to_send_out), .rx_byte_available(rx_byte_available),
        .irq(irq), .mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr),
        .mem_wr_data(mem_wr_data));
    line_partner #(.BT(BT)) i_partner (.sys_clk(sys_clk), .serial_tx_line(serial_tx_line),
        .request_to_send_out(request_to_send_out), .serial_rx_line(serial_rx_line),
        .clear_to_send_in(clear_to_send_in));

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        if (mem_wr_en === 1'b1) begin
            mem_log.push_back({mem_wr_addr, mem_wr_data});
        end
    end

    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic check_near(input int got, input int exp, input string what);
        check({15'h0000, (got >= exp - 3) && (got <= exp + 3)}, 16'h0001, what);
    endtask
    task automatic reg_write(input reg_addr_t a, input reg_data_t d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic expect_reg(input reg_addr_t a, input reg_data_t exp, input string what);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 check(reg_rdata, exp, what);
    endtask
    // Counts cycles until the level shows, bounded
    task automatic wait_val(ref logic s, input logic v, output int cnt);
        cnt = 0;
        while (s !== v && cnt < 5000) begin
            @(posedge sys_clk);
            #1;
            cnt++;
        end
        check({15'h0000, s}, {15'h0000, v}, "wait for level");
    endtask
    // Byte 0x35 keeps bit 7 low, so the stop interval ends the frame
    task automatic tx_frame(input reg_data_t ctrl, input reg_data_t gap, input int stop_bt);
        reg_write(`SP_CTRL_OFS, ctrl);
        reg_write(`SP_GAP_OFS, gap);
        reg_write(`SP_TXDATA_OFS, 16'h0035);
        wait_val(serial_tx_line, 1'b0, n);
        wait_val(irq, 1'b1, n);
        check_near(n, (9 + stop_bt) * BT, "frame length");
        check({8'h00, i_partner.got_byte}, 16'h0035, "byte on line");
        expect_reg(`SP_IRQ_STAT_OFS, 16'h0002, "tx done status");
        repeat (3) @(posedge sys_clk);
        check({15'h0000, irq}, 16'h0000, "irq after clear");
        $display("test transmit stop %0d done", stop_bt);
    endtask

    initial begin
        #200us;
        bad_count++;
        give_verdict();
    end
    initial begin
        rstn = 1'b0;
        ce = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 16'h0000;
        reg_wdata = 16'h0000;
        repeat (4) @(posedge sys_clk);
        rstn <= 1'b1;
        expect_reg(`SP_GAP_OFS, `SP_GAP_RST, "gap reset");
        expect_reg(16'hC0FE, 16'h0000, "unmapped read");
        expect_reg(`SP_STATUS_OFS, 16'h0000, "idle status");
        check({14'h0000, serial_tx_line, request_to_send_out}, 16'h0002, "idle");
        // Write while the enable is low must not land
        @(posedge sys_clk);
        ce <= 1'b0;
        reg_write(`SP_GAP_OFS, 16'h0020);
        ce <= 1'b1;
        expect_reg(`SP_GAP_OFS, `SP_GAP_RST, "gap frozen by enable");
        $display("test reset done");
        reg_write(`SP_IRQ_MASK_OFS, 16'h0002);
        tx_frame(16'h0001, `SP_GAP_RST, 2);
        tx_frame(16'h0000, 16'h000E, 1);
        tx_frame(16'h0001, 16'h000E, 5);
        // Flow control with the completion interrupt masked
        reg_write(`SP_IRQ_MASK_OFS, 16'h0000);
        reg_write(`SP_CTRL_OFS, 16'h0004);
        @(negedge sys_clk);
        i_partner.cts_hold = 1'b1;
        repeat (4) @(posedge sys_clk);
        reg_write(`SP_TXDATA_OFS, 16'h00C4);
        repeat (200) @(posedge sys_clk);
        check({14'h0000, request_to_send_out, serial_tx_line}, 16'h0003, "held");
        @(negedge sys_clk);
        i_partner.cts_hold = 1'b0;
        wait_val(serial_tx_line, 1'b0, n);
        wait_val(request_to_send_out, 1'b0, n);
        check_near(n, 3 * BT, "request drop");
        repeat (10 * BT) @(posedge sys_clk);
        check({8'h00, i_partner.got_byte}, 16'h00C4, "flow byte");
        check({15'h0000, irq}, 16'h0000, "masked irq");
        expect_reg(`SP_IRQ_STAT_OFS, 16'h0002, "masked status");
        $display("test flow control done");
        reg_write(`SP_CTRL_OFS, 16'h0000);
        for (int k = 0; k < 3; k++) begin
            i_partner.send_byte(rx_data[k], BTNS * rx_scale[k]);
            wait_val(rx_byte_available, 1'b1, n);
            expect_reg(`SP_RXDATA_OFS, {8'h00, rx_data[k]}, "rx byte");
            repeat (3) @(posedge sys_clk);
            check({15'h0000, rx_byte_available}, 16'h0000, "fifo empty");
        end
        $display("test byte receive done");
        reg_write(`SP_BLK_ADDR_OFS, 16'h0100);
        reg_write(`SP_CTRL_OFS, 16'h0002);
        i_partner.send_byte(8'h96, BTNS);
        i_partner.send_byte(8'h69, BTNS);
        check({15'h0000, rx_byte_available}, 16'h0000, "no fifo use");
        check(16'(mem_log.size()), 16'h0002, "memory writes");
        for (int k = 0; k < 2 && k < mem_log.size(); k++) begin
            check(mem_log[k][23:8], 16'h0100 + 16'(k), "memory address");
            check({8'h00, mem_log[k][7:0]}, k == 0 ? 16'h0096 : 16'h0069, "memory byte");
        end
        $display("test block receive done");
        give_verdict();
    end
endmodule // high_speed_serial_port_tb
`default_nettype wire
